// File: src/ccrd_decoder.sv
// Reset-time decoder for the core clock configuration field.
`timescale 1ns/1ps
`include "ccrd_defs.svh"
module ccrd_decoder
  import ccrd_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [`CCRD_FIELD_W-1:0] coreClockConfigField,
  output ccrd_cfg_s coreCfg_ff
);

  function automatic ccrd_cfg_s decodeField(input logic [`CCRD_FIELD_W-1:0] f);
    logic [1:0] d;
    logic [3:0] r;
    logic h;
    ccrd_cfg_s c;
    d = f[`CCRD_DIV_MSB:`CCRD_DIV_LSB];
    r = f[`CCRD_RAT_MSB:`CCRD_RAT_LSB];
    h = f[`CCRD_HALF_BIT];
    c.ratio = RATIO_RESERVED;
    c.vcoDivider = 4'h0;
    c.pllBypass = 1'b0;
    c.reserved = 1'b0;
    if (r == `CCRD_RAT_BYP && !h)
    begin
      c.ratio = RATIO_BYPASS;
      c.pllBypass = 1'b1;
    end
    else
    begin
      case ({r, h})
        {`CCRD_RAT_X1, 1'b0}: c.ratio = RATIO_1_0;
        {`CCRD_RAT_X1, 1'b1}: c.ratio = RATIO_1_5;
        {`CCRD_RAT_X2, 1'b0}: c.ratio = RATIO_2_0;
        {`CCRD_RAT_X2, 1'b1}: c.ratio = RATIO_2_5;
        {`CCRD_RAT_X3, 1'b0}: c.ratio = RATIO_3_0;
        default: c.reserved = 1'b1;
      endcase
      case (d)
        `CCRD_DIV_CODE2: c.vcoDivider = `CCRD_DIV_VAL2;
        `CCRD_DIV_CODE4: c.vcoDivider = `CCRD_DIV_VAL4;
        `CCRD_DIV_CODE8: c.vcoDivider = `CCRD_DIV_VAL8;
        default: c.reserved = 1'b1;
      endcase
      // Reserved codes are flagged rather than trusted; the source must avoid them.
      if (c.reserved)
      begin
        c.ratio = RATIO_RESERVED;
        c.vcoDivider = 4'h0;
      end
    end
    return c;
  endfunction

  logic capturing_ff;
  ccrd_cfg_s nxt_coreCfg;

  assign nxt_coreCfg = decodeField(coreClockConfigField);

  // Reset loads constants only; the field is caught on the first edge after release.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      capturing_ff <= 1'b1;
    else
      capturing_ff <= 1'b0;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      coreCfg_ff <= '{ratio: RATIO_BYPASS, vcoDivider: 4'h0, pllBypass: 1'b1, reserved: 1'b0};
    else if (capturing_ff)
      coreCfg_ff <= nxt_coreCfg;
  end

  // The raw field is kept beside the settings so the checks below judge every cycle
  // after capture. Its reset value is the bypass code, which decodes to the reset
  // settings, so no check needs a gap around the release of reset.
  logic [`CCRD_FIELD_W-1:0] capturedField_ff;
  logic [4:0] capRatioCode;
  logic [1:0] capDivCode;
  logic listedRatio;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      capturedField_ff <= 7'h00;
    else if (capturing_ff)
      capturedField_ff <= coreClockConfigField;
  end

  assign capRatioCode = capturedField_ff[`CCRD_HALF_BIT:`CCRD_RAT_LSB];
  assign capDivCode = capturedField_ff[`CCRD_DIV_MSB:`CCRD_DIV_LSB];
  assign listedRatio = capRatioCode inside {5'h01, 5'h11, 5'h02, 5'h12, 5'h03};

  // Expected settings are written out from the encoding table, not from the decode
  // function, so a slip in the function cannot hide behind its own checker.
  AST_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    !$past(capturing_ff)
    |-> $stable(coreCfg_ff))
    else $error("Decoded clock settings changed after capture.");

  AST_FIELD_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    !$past(capturing_ff)
    |-> $stable(capturedField_ff))
    else $error("Captured field changed after capture.");

  AST_CAPTURE: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(capturing_ff)
    |-> capturedField_ff == $past(coreClockConfigField))
    else $error("Field was not taken at the first edge after reset.");

  AST_ONESHOT: assert property (@(posedge mclk) disable iff (!nrst)
    !capturing_ff
    |=> !capturing_ff)
    else $error("Capture window reopened without reset.");

  AST_BYPASS: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h00
    |-> coreCfg_ff.pllBypass && coreCfg_ff.ratio == RATIO_BYPASS)
    else $error("Bypass encoding did not bypass the PLL.");

  AST_BYP_DIV0: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h00
    |-> coreCfg_ff.vcoDivider == 4'h0 && !coreCfg_ff.reserved)
    else $error("Bypass encoding left a divider or a reserved flag.");

  AST_BYP_ANYDIV: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h00 && capDivCode == 2'h3
    |-> coreCfg_ff.pllBypass && !coreCfg_ff.reserved)
    else $error("Bypass with divider code 11 was not a bypass.");

  AST_NOBYP: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode != 5'h00
    |-> !coreCfg_ff.pllBypass)
    else $error("PLL bypassed for a non-bypass encoding.");

  AST_BYP_CONSIST: assert property (@(posedge mclk) disable iff (!nrst)
    coreCfg_ff.pllBypass
    |-> coreCfg_ff.ratio == RATIO_BYPASS && !coreCfg_ff.reserved)
    else $error("Bypass flag inconsistent with ratio.");

  AST_R10: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h01 && capDivCode != 2'h3
    |-> coreCfg_ff.ratio == RATIO_1_0)
    else $error("Ratio 1 decoded wrongly.");

  AST_R15: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h11 && capDivCode != 2'h3
    |-> coreCfg_ff.ratio == RATIO_1_5)
    else $error("Ratio 1.5 decoded wrongly.");

  AST_R20: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h02 && capDivCode != 2'h3
    |-> coreCfg_ff.ratio == RATIO_2_0)
    else $error("Ratio 2 decoded wrongly.");

  AST_R25: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h12 && capDivCode != 2'h3
    |-> coreCfg_ff.ratio == RATIO_2_5)
    else $error("Ratio 2.5 decoded wrongly.");

  AST_RATIO25: assert property (@(posedge mclk) disable iff (!nrst)
    capturedField_ff == 7'h48
    |-> coreCfg_ff.ratio == RATIO_2_5 && coreCfg_ff.vcoDivider == 4'h2)
    else $error("Ratio 2.5 with divider 2 decoded wrongly.");

  AST_R30: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode == 5'h03 && capDivCode != 2'h3
    |-> coreCfg_ff.ratio == RATIO_3_0)
    else $error("Ratio 3 decoded wrongly.");

  AST_DIV2: assert property (@(posedge mclk) disable iff (!nrst)
    listedRatio && capDivCode == 2'h0
    |-> coreCfg_ff.vcoDivider == 4'h2)
    else $error("Divider code 00 did not give 2.");

  AST_DIV4: assert property (@(posedge mclk) disable iff (!nrst)
    listedRatio && capDivCode == 2'h1
    |-> coreCfg_ff.vcoDivider == 4'h4)
    else $error("Divider code 01 did not give 4.");

  AST_DIV8: assert property (@(posedge mclk) disable iff (!nrst)
    listedRatio && capDivCode == 2'h2
    |-> coreCfg_ff.vcoDivider == 4'h8)
    else $error("Divider code 10 did not give 8.");

  AST_DIV_LEGAL: assert property (@(posedge mclk) disable iff (!nrst)
    listedRatio && capDivCode != 2'h3
    |-> coreCfg_ff.vcoDivider == (4'h2 << capDivCode) && !coreCfg_ff.reserved)
    else $error("Divider not taken from the low field bits.");

  AST_RESV: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode != 5'h00 && capDivCode == 2'h3
    |-> coreCfg_ff.reserved)
    else $error("Reserved divider code not flagged.");

  AST_RESV_RATIO: assert property (@(posedge mclk) disable iff (!nrst)
    capRatioCode != 5'h00 && !listedRatio
    |-> coreCfg_ff.reserved)
    else $error("Unlisted ratio code not flagged.");

  AST_LISTED: assert property (@(posedge mclk) disable iff (!nrst)
    listedRatio && capDivCode != 2'h3
    |-> !coreCfg_ff.reserved)
    else $error("Listed encoding flagged as reserved.");

  AST_RESV_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    coreCfg_ff.reserved
    |-> coreCfg_ff.ratio == RATIO_RESERVED && coreCfg_ff.vcoDivider == 4'h0 && !coreCfg_ff.pllBypass)
    else $error("Reserved encoding left live settings.");

  // Covers mark the main captures seen by the scenarios.
  COV_BYPASS: cover property (@(posedge mclk) disable iff (!nrst)
    $fell(capturing_ff) && coreCfg_ff.pllBypass);

  COV_R30: cover property (@(posedge mclk) disable iff (!nrst)
    $fell(capturing_ff) && coreCfg_ff.ratio == RATIO_3_0);

  COV_R15: cover property (@(posedge mclk) disable iff (!nrst)
    $fell(capturing_ff) && coreCfg_ff.ratio == RATIO_1_5);

  COV_RESV: cover property (@(posedge mclk) disable iff (!nrst)
    $fell(capturing_ff) && coreCfg_ff.reserved);

  COV_DIV4: cover property (@(posedge mclk) disable iff (!nrst)
    $fell(capturing_ff) && coreCfg_ff.vcoDivider == 4'h4);

endmodule

// File: src/ccrd_defs.svh
// Constants for the core clock ratio decoder.
`ifndef CCRD_DEFS_SVH
`define CCRD_DEFS_SVH
`define CCRD_FIELD_W 7
`define CCRD_DIV_LSB 0
`define CCRD_DIV_MSB 1
`define CCRD_RAT_LSB 2
`define CCRD_RAT_MSB 5
`define CCRD_HALF_BIT 6
`define CCRD_DIV_CODE2 2'h0
`define CCRD_DIV_CODE4 2'h1
`define CCRD_DIV_CODE8 2'h2
`define CCRD_RAT_BYP 4'h0
`define CCRD_RAT_X1 4'h1
`define CCRD_RAT_X2 4'h2
`define CCRD_RAT_X3 4'h3
`define CCRD_DIV_VAL2 4'h2
`define CCRD_DIV_VAL4 4'h4
`define CCRD_DIV_VAL8 4'h8
`endif

// File: src/ccrd_pkg.sv
// Types shared by the core clock ratio decoder.
package ccrd_pkg;
  typedef enum logic [2:0] {RATIO_BYPASS, RATIO_1_0, RATIO_1_5, RATIO_2_0, RATIO_2_5,
    RATIO_3_0, RATIO_RESERVED} ccrd_ratio_e;
  typedef struct packed {
    ccrd_ratio_e ratio;
    logic [3:0] vcoDivider;
    logic pllBypass;
    logic reserved;
  } ccrd_cfg_s;
endpackage

// File: sim/ccrd_cfg_src.sv
// Model of the reset configuration word source that feeds the decoder.
`timescale 1ns/1ps
module ccrd_cfg_src
(
  input wire logic mclk,
  input wire logic [6:0] wantField,
  output logic [6:0] field
);
  // Unlisted codes go out only when the bench asks, to probe the reserved decode.
  always @(posedge mclk)
  begin
    field <= wantField;
  end
endmodule

// File: sim/tb_top.sv
// Testbench for the core clock ratio decoder.
`timescale 1ns/1ps
module tb_top;
  import ccrd_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] want = 7'h00;
  logic [6:0] field;
  ccrd_cfg_s cfg;
  int n_fail = 0;
  int n_tests = 0;
  always #5 mclk = ~mclk;
  ccrd_cfg_src SRC (.mclk(mclk), .wantField(want), .field(field));
  ccrd_decoder DUT (.mclk(mclk), .nrst(nrst), .coreClockConfigField(field), .coreCfg_ff(cfg));
  task automatic check(input ccrd_cfg_s seen, input ccrd_cfg_s exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t decode %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // A later change of the field must leave the captured settings untouched.
  task automatic boot(input logic [6:0] f, input ccrd_cfg_s exp);
    @(posedge mclk);
    nrst <= 1'b0;
    want <= f;
    repeat (20) @(posedge mclk);
    check(cfg, '{RATIO_BYPASS, 4'h0, 1'b1, 1'b0});
    nrst <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    check(cfg, exp);
    @(posedge mclk);
    want <= ~f;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check(cfg, exp);
  endtask
  task automatic t_bypass();
    for (int d = 0; d < 4; d++)
      boot({5'h00, 2'(d)}, '{RATIO_BYPASS, 4'h0, 1'b1, 1'b0});
  endtask
  task automatic t_ratios();
    ccrd_ratio_e re [5] = '{RATIO_1_0, RATIO_1_5, RATIO_2_0, RATIO_2_5, RATIO_3_0};
    for (int r = 0; r < 5; r++)
      for (int d = 0; d < 3; d++)
        boot({r[0], 4'((r + 2) / 2), 2'(d)}, '{re[r], 4'(2 << d), 1'b0, 1'b0});
  endtask
  task automatic t_reserved();
    logic [6:0] codes [5] = '{7'h07, 7'h13, 7'h10, 7'h40, 7'h4d};
    for (int i = 0; i < 5; i++)
      boot(codes[i], '{RATIO_RESERVED, 4'h0, 1'b0, 1'b1});
  endtask
  initial
  begin
    t_bypass();
    t_ratios();
    t_reserved();
    end_of_test();
  end
  initial
  begin
    #20us;
    n_fail++;
    end_of_test();
  end
endmodule
